// ### fsc_pkg.sv
package fsc_pkg;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          STEP_UNIT_US  = 1000;
  localparam int          STEP_UNIT_CYC = STEP_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [7:0]  OP_SEEK       = 8'h0F;
  localparam logic [5:0]  OP_RSEEK_LOW  = 6'h0F;
  localparam logic [5:0]  OP_STRK_LOW   = 6'h21;
  localparam logic [7:0]  OP_SENSE_DRV  = 8'h04;
  localparam logic [7:0]  OP_SENSE_INT  = 8'h08;
  localparam logic [7:0]  OP_SPECIFY    = 8'h03;
  localparam logic [7:0]  OP_VERSION    = 8'h10;
  localparam logic [4:0]  OP_SCAN_EQ    = 5'h11;
  localparam logic [4:0]  OP_SCAN_HE    = 5'h1D;
  localparam logic [4:0]  OP_SCAN_LE    = 5'h19;
  localparam logic [4:0]  OP_VERIFY     = 5'h16;
  localparam logic [7:0]  ST0_SEEK_END  = 8'h20;
  localparam logic [7:0]  ST0_INVALID   = 8'h80;
  localparam logic [7:0]  ST2_SCAN_HIT  = 8'h08;
  localparam logic [7:0]  ST2_SCAN_MISS = 8'h04;
  localparam logic [11:0] PTR_RST       = 12'h000;
  localparam logic [3:0]  NIB_RST       = 4'h0;
  localparam logic [6:0]  MNT_RST       = 7'h00;
  localparam logic [2:0]  DISK_RES_LEN  = 3'h7;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_CMD = 3'b001, S_GO = 3'b010,
    S_SEEK = 3'b011, S_DISK = 3'b100, S_RES = 3'b101
  } fsc_state_t;

  typedef enum logic [3:0] {
    K_RSEEK = 4'b0000, K_SEEK = 4'b0001, K_SCAN = 4'b0010,
    K_SDRV  = 4'b0011, K_SINT = 4'b0100, K_STRK = 4'b0101,
    K_SPEC  = 4'b0110, K_VRFY = 4'b0111, K_VER  = 4'b1000,
    K_BAD   = 4'b1001
  } fsc_kind_t;

  function automatic fsc_kind_t fsc_decode(input logic [7:0] b);
    if (b[7] && b[5:0] == OP_RSEEK_LOW) return K_RSEEK;
    if (!b[7] && b[5:0] == OP_STRK_LOW) return K_STRK;
    if (b == OP_SEEK) return K_SEEK;
    if (b == OP_SENSE_DRV) return K_SDRV;
    if (b == OP_SENSE_INT) return K_SINT;
    if (b == OP_SPECIFY) return K_SPEC;
    if (b == OP_VERSION) return K_VER;
    if (b[4:0] == OP_VERIFY) return K_VRFY;
    if (b[4:0] == OP_SCAN_EQ || b[4:0] == OP_SCAN_HE
        || b[4:0] == OP_SCAN_LE) return K_SCAN;
    return K_BAD;
  endfunction

  function automatic logic [3:0] fsc_len(input fsc_kind_t k,
                                         input logic extended_track_range);
    case (k)
      K_RSEEK, K_STRK, K_SPEC: return 4'h3;
      K_SEEK:                  return extended_track_range ? 4'h4 : 4'h3;
      K_SCAN, K_VRFY:          return 4'h9;
      K_SDRV:                  return 4'h2;
      default:                 return 4'h1;
    endcase
  endfunction
endpackage

// ### fsc_step_if.sv
interface fsc_step_if;
  logic        start;
  logic        dirIn;
  logic [11:0] count;
  logic [3:0]  rate;
  logic        busy;
  logic        done;
  logic        stepPulse;
  modport ctrl (output start, dirIn, count, rate,
                input  busy, done, stepPulse);
  modport eng  (input  start, dirIn, count, rate,
                output busy, done, stepPulse);
endinterface

// ### fsc_stepper.sv
module fsc_stepper #(
  parameter int UNIT_CYC = fsc_pkg::STEP_UNIT_CYC
) (
  input wire logic   clk,   // Core clock
  input wire logic   rst_b, // Async reset, active low
  fsc_step_if.eng    st     // Step request and pulses
);
  import fsc_pkg::*;
  logic [11:0] remain, next_remain;
  logic [31:0] timer, next_timer;
  logic        busy, next_busy;
  logic        done, next_done;
  logic        pulse, next_pulse;
  logic [11:0] seen, want;

  function automatic logic [31:0] interval(input logic [3:0] r);
    return (32'd16 - {28'h0, r}) * UNIT_CYC[31:0] - 32'd1;
  endfunction

  always_comb begin
    next_remain = remain;
    next_timer  = timer;
    next_busy   = busy;
    next_done   = 1'b0;
    next_pulse  = 1'b0;
    if (st.start) begin
      next_remain = st.count;
      next_timer  = interval(st.rate);
      next_busy   = (st.count != 12'h000);
      next_done   = (st.count == 12'h000);
    end else if (busy) begin
      if (timer == 32'h0) begin
        next_pulse  = 1'b1;
        next_remain = remain - 12'h001;
        next_timer  = interval(st.rate);
        if (remain == 12'h001) begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end
      end else begin
        next_timer = timer - 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      remain <= 12'h000;
      timer  <= 32'h0;
      busy   <= 1'b0;
      done   <= 1'b0;
      pulse  <= 1'b0;
    end else begin
      remain <= next_remain;
      timer  <= next_timer;
      busy   <= next_busy;
      done   <= next_done;
      pulse  <= next_pulse;
    end
  end

  assign st.busy      = busy;
  assign st.done      = done;
  assign st.stepPulse = pulse;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen <= 12'h000;
      want <= 12'h000;
    end else if (st.start) begin
      seen <= 12'h000;
      want <= st.count;
    end else if (pulse) begin
      seen <= seen + 12'h001;
    end
  end

  property p_step_count;
    // Last pulse stands in the same cycle as done
    @(posedge clk) disable iff (!rst_b)
      done |-> seen + {11'h000, pulse} == want;
  endproperty
  a_step_count: assert property (p_step_count)
    else $error("step pulse count differs from request");
endmodule

// ### fsc_cmd.sv
module fsc_cmd #(
  parameter int         UNIT_CYC   = fsc_pkg::STEP_UNIT_CYC,
  parameter logic [7:0] VERSION_ID = 8'h90
) (
  input  wire logic        clk,                // Core clock
  input  wire logic        rst_b,              // Async reset, active low
  input  wire logic        cmdValid,           // Command byte offered
  input  wire logic [7:0]  cmdData,            // Command byte
  output logic             cmdReady,           // Command byte taken
  output logic             resValid,           // Result byte offered
  output logic [7:0]       resData,            // Result byte
  input  wire logic        resReady,           // Result byte taken
  input  wire logic        extendedTrackRange, // Extended track mode
  input  wire logic [7:0]  driveStatus,        // Drive status byte
  input  wire logic        diskValid,          // Disk byte offered
  input  wire logic [7:0]  diskData,           // Disk byte
  output logic             diskReady,          // Disk byte taken
  input  wire logic        diskSectorEnd,      // Sector finished pulse
  input  wire logic        diskTrackEnd,       // Track finished pulse
  input  wire logic        scanValid,          // Host compare byte valid
  input  wire logic [7:0]  scanData,           // Host compare byte
  output logic             scanReady,          // Host compare byte taken
  output logic             execActive,         // Disk execution running
  output logic             encodingSelect,     // Recording method
  output logic             multiTrackEnable,   // Multi-track active
  output logic             skipDeletedEnable,  // Skip deleted sectors
  output logic             headSelect,         // Current head
  output logic [1:0]       execDrive,          // Selected drive
  output logic [7:0]       execSector,         // Current sector
  output logic [7:0]       execSectorSize,     // Bytes per sector code
  output logic [7:0]       execLength,         // Length or count byte
  output logic             countEnableBit,     // Length is sector count
  output logic             stepOut,            // Head step pulse
  output logic             stepDir,            // Step in when high
  output logic             irq,                // Interrupt request
  output logic [3:0]       stepRateTime,       // Stored step rate
  output logic [3:0]       motorOffTime,       // Stored motor off time
  output logic [6:0]       motorOnTime,        // Stored motor on time
  output logic             nonDmaSelect        // Stored transfer select
);
  import fsc_pkg::*;
  fsc_state_t  state, next_state;
  fsc_kind_t   kind, next_kind;
  logic [7:0]  cmdBuf [9];
  logic [7:0]  next_cmdBuf [9];
  logic [7:0]  res [7];
  logic [7:0]  next_res [7];
  logic [11:0] ptr [4];
  logic [11:0] next_ptr [4];
  logic [3:0]  nbytes, next_nbytes;
  logic [2:0]  resLeft, next_resLeft;
  logic [11:0] seekTarget, next_seekTarget;
  logic        intPend, next_intPend;
  logic [7:0]  intSt0, next_intSt0;
  logic [1:0]  intDrive, next_intDrive;
  logic        head, next_head;
  logic [7:0]  sector, next_sector;
  logic [7:0]  secDone, next_secDone;
  logic        miss, next_miss;
  logic        stStart, next_stStart;
  logic [3:0]  srt, next_srt, mft, next_mft;
  logic [6:0]  mnt, next_mnt;
  logic        nd, next_nd;
  logic [1:0]  drv;
  logic        beat, cmpOk, finish;
  fsc_kind_t   k0;
  fsc_step_if  step ();

  fsc_stepper #(.UNIT_CYC(UNIT_CYC)) u_step (
    .clk   (clk),
    .rst_b (rst_b),
    .st    (step)
  );

  function automatic logic scan_ok(input logic [4:0] op,
                                   input logic [7:0] d, h);
    case (op)
      OP_SCAN_HE: return d >= h;
      OP_SCAN_LE: return d <= h;
      default:    return d == h;
    endcase
  endfunction

  assign drv       = cmdBuf[1][1:0];
  assign k0        = (nbytes == 4'h0) ? fsc_decode(cmdData) : kind;
  assign cmdReady  = (state == S_IDLE) || (state == S_CMD);
  assign resValid  = (state == S_RES);
  assign resData   = res[0];
  assign scanReady = (state == S_DISK) && (kind == K_SCAN) && diskValid;
  assign diskReady = (state == S_DISK) && ((kind != K_SCAN) || scanValid);
  assign beat      = diskValid && diskReady;
  assign cmpOk     = scan_ok(cmdBuf[0][4:0], diskData, scanData);
  assign execActive        = (state == S_DISK);
  assign encodingSelect    = cmdBuf[0][6];
  assign multiTrackEnable  = cmdBuf[0][7];
  assign skipDeletedEnable = cmdBuf[0][5];
  assign headSelect        = head;
  assign execDrive         = drv;
  assign execSector        = sector;
  assign execSectorSize    = cmdBuf[5];
  assign execLength        = cmdBuf[8];
  assign countEnableBit    = (kind == K_VRFY) && cmdBuf[1][7];
  assign step.start = stStart;
  assign step.count = (kind == K_RSEEK) ? {4'h0, cmdBuf[2]}
                    : (seekTarget > ptr[drv]) ? seekTarget - ptr[drv]
                    : ptr[drv] - seekTarget;
  assign step.dirIn = (kind == K_RSEEK) ? cmdBuf[0][6]
                                        : (seekTarget > ptr[drv]);
  assign step.rate  = srt;
  assign stepOut    = step.stepPulse;
  assign stepDir    = step.dirIn;
  assign irq        = intPend;
  assign stepRateTime = srt;
  assign motorOffTime = mft;
  assign motorOnTime  = mnt;
  assign nonDmaSelect = nd;

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_cmdBuf = cmdBuf;
    next_res = res;
    next_ptr = ptr;
    next_nbytes = nbytes;
    next_resLeft = resLeft;
    next_seekTarget = seekTarget;
    next_intPend = intPend;
    next_intSt0 = intSt0;
    next_intDrive = intDrive;
    next_head = head;
    next_sector = sector;
    next_secDone = secDone;
    next_miss = miss;
    next_stStart = 1'b0;
    next_srt = srt;
    next_mft = mft;
    next_mnt = mnt;
    next_nd = nd;
    finish = 1'b0;
    case (state)
      S_IDLE, S_CMD: begin
        if (cmdValid) begin
          next_cmdBuf[nbytes] = cmdData;
          next_kind = k0;
          next_state = S_CMD;
          next_nbytes = nbytes + 4'h1;
          if (nbytes + 4'h1 == fsc_len(k0, extendedTrackRange)) begin
            next_state = S_GO;
            next_nbytes = 4'h0;
          end
        end
      end
      S_GO: begin
        next_state = S_RES;
        next_resLeft = 3'h1;
        case (kind)
          K_SEEK: begin
            next_seekTarget = extendedTrackRange
                ? {cmdBuf[3][7:4], cmdBuf[2]} : {4'h0, cmdBuf[2]};
            next_stStart = 1'b1;
            next_state = S_SEEK;
          end
          K_RSEEK: begin
            next_seekTarget = cmdBuf[0][6]
                ? ptr[drv] + {4'h0, cmdBuf[2]}
                : ptr[drv] - {4'h0, cmdBuf[2]};
            next_stStart = 1'b1;
            next_state = S_SEEK;
          end
          K_SCAN, K_VRFY: begin
            next_head = cmdBuf[1][2];
            next_sector = cmdBuf[4];
            next_secDone = 8'h00;
            next_miss = 1'b0;
            next_state = S_DISK;
          end
          K_SDRV: next_res[0] = driveStatus;
          K_SINT: begin
            next_res[0] = intPend ? intSt0 : ST0_INVALID;
            next_res[1] = ptr[intDrive][7:0];
            next_res[2] = {ptr[intDrive][11:8], 4'h0};
            if (intPend) begin
              next_resLeft = extendedTrackRange ? 3'h3 : 3'h2;
            end
            next_intPend = 1'b0;
          end
          K_STRK: begin
            if (cmdBuf[0][6] && cmdBuf[1][2]) begin
              next_ptr[drv][11:8] = cmdBuf[2][3:0];
            end else if (cmdBuf[0][6]) begin
              next_ptr[drv][7:0] = cmdBuf[2];
            end
            next_res[0] = cmdBuf[1][2] ? {4'h0, next_ptr[drv][11:8]}
                                       : next_ptr[drv][7:0];
          end
          K_SPEC: begin
            next_srt = cmdBuf[1][7:4];
            next_mft = cmdBuf[1][3:0];
            next_mnt = cmdBuf[2][7:1];
            next_nd = cmdBuf[2][0];
            next_state = S_IDLE;
          end
          K_VER: next_res[0] = VERSION_ID;
          default: next_res[0] = ST0_INVALID;
        endcase
      end
      S_SEEK: begin
        if (step.done) begin
          next_ptr[drv] = seekTarget;
          next_intPend = 1'b1;
          next_intSt0 = ST0_SEEK_END | {5'h00, cmdBuf[1][2:0]};
          next_intDrive = drv;
          next_state = S_IDLE;
        end
      end
      S_DISK: begin
        if (beat && kind == K_SCAN && !cmpOk) begin
          next_miss = 1'b1;
        end
        if (diskSectorEnd) begin
          next_sector = sector + ((kind == K_SCAN) ? cmdBuf[8] : 8'h01);
          next_secDone = secDone + 8'h01;
          if (countEnableBit && secDone + 8'h01 == cmdBuf[8]) begin
            finish = 1'b1;
          end
        end
        if (diskTrackEnd && !finish) begin
          if (multiTrackEnable && !head) begin
            next_head = 1'b1;
            next_sector = 8'h01;
          end else begin
            finish = 1'b1;
          end
        end
        if (finish) begin
          next_res[0] = {5'h00, next_head, drv};
          next_res[1] = 8'h00;
          next_res[2] = (kind != K_SCAN) ? 8'h00
                      : next_miss ? ST2_SCAN_MISS : ST2_SCAN_HIT;
          next_res[3] = cmdBuf[2];
          next_res[4] = {7'h00, next_head};
          next_res[5] = next_sector;
          next_res[6] = cmdBuf[5];
          next_resLeft = DISK_RES_LEN;
          next_state = S_RES;
        end
      end
      S_RES: begin
        if (resReady) begin
          for (int i = 0; i < 6; i++) begin
            next_res[i] = res[i + 1];
          end
          next_resLeft = resLeft - 3'h1;
          if (resLeft == 3'h1) begin
            next_state = S_IDLE;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      kind <= K_BAD;
      cmdBuf <= '{default: 8'h00};
      res <= '{default: 8'h00};
      ptr <= '{default: PTR_RST};
      nbytes <= 4'h0;
      resLeft <= 3'h0;
      seekTarget <= PTR_RST;
      intPend <= 1'b0;
      intSt0 <= 8'h00;
      intDrive <= 2'h0;
      head <= 1'b0;
      sector <= 8'h00;
      secDone <= 8'h00;
      miss <= 1'b0;
      stStart <= 1'b0;
      srt <= NIB_RST;
      mft <= NIB_RST;
      mnt <= MNT_RST;
      nd <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      cmdBuf <= next_cmdBuf;
      res <= next_res;
      ptr <= next_ptr;
      nbytes <= next_nbytes;
      resLeft <= next_resLeft;
      seekTarget <= next_seekTarget;
      intPend <= next_intPend;
      intSt0 <= next_intSt0;
      intDrive <= next_intDrive;
      head <= next_head;
      sector <= next_sector;
      secDone <= next_secDone;
      miss <= next_miss;
      stStart <= next_stStart;
      srt <= next_srt;
      mft <= next_mft;
      mnt <= next_mnt;
      nd <= next_nd;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_seek_end;
    (state == S_SEEK && step.done) |=> state == S_IDLE && !resValid && irq;
  endproperty
  a_seek_end: assert property (p_seek_end)
    else $error("seek end without interrupt or with result");
  property p_seek_ptr;
    (state == S_SEEK && step.done) |=> ptr[$past(drv)] == $past(seekTarget);
  endproperty
  a_seek_ptr: assert property (p_seek_ptr)
    else $error("track register not at seek target");
  property p_sdrv;
    (state == S_GO && kind == K_SDRV)
      |=> resValid && resLeft == 3'h1 && resData == $past(driveStatus);
  endproperty
  a_sdrv: assert property (p_sdrv)
    else $error("drive status result wrong");
  property p_sint_len;
    (state == S_GO && kind == K_SINT && intPend)
      |=> resLeft == ($past(extendedTrackRange) ? 3'h3 : 3'h2) && !irq;
  endproperty
  a_sint_len: assert property (p_sint_len)
    else $error("sense interrupt result length wrong");
  property p_ver;
    (state == S_GO && kind == K_VER) |=> resData == VERSION_ID ##0 resLeft == 3'h1;
  endproperty
  a_ver: assert property (p_ver)
    else $error("version byte wrong");
  property p_spec;
    (state == S_GO && kind == K_SPEC) |=> state == S_IDLE
      && stepRateTime == $past(cmdBuf[1][7:4]) && nonDmaSelect == $past(cmdBuf[2][0]);
  endproperty
  a_spec: assert property (p_spec)
    else $error("specify values not stored");
  property p_disk_res;
    (state == S_DISK ##1 state == S_RES) |-> resLeft == 3'h7 ##0 resValid;
  endproperty
  a_disk_res: assert property (p_disk_res)
    else $error("disk command result count wrong");
  property p_mt;
    (state == S_DISK && diskTrackEnd && !diskSectorEnd && multiTrackEnable && !head)
      |=> state == S_DISK && head && sector == 8'h01;
  endproperty
  a_mt: assert property (p_mt)
    else $error("multi-track head switch missing");
  property p_scan_miss;
    (state == S_DISK && kind == K_SCAN && beat && !cmpOk) |=> miss;
  endproperty
  a_scan_miss: assert property (p_scan_miss)
    else $error("scan mismatch not recorded");
  c_seek: cover property (state == S_SEEK && step.done);
  c_scan: cover property (state == S_DISK && kind == K_SCAN ##1 state == S_RES);
  c_sint3: cover property (state == S_RES && kind == K_SINT && resLeft == 3'h3);
  c_mt: cover property (state == S_DISK && diskTrackEnd && multiTrackEnable && !head);
endmodule

// ### fsc_drive_model.sv
module fsc_drive_model #(
  parameter logic [7:0] PAT       = 8'hA5,
  parameter int         SEC_BYTES = 4,
  parameter int         TRK_SECS  = 3
) (
  input  wire logic        clk,           // Core clock
  input  wire logic        rst_b,         // Async reset, active low
  input  wire logic        execActive,    // Disk execution running
  input  wire logic        diskReady,     // Disk byte taken
  input  wire logic        stepOut,       // Head step pulse
  input  wire logic        stepDir,       // Step in when high
  output logic             diskValid,     // Disk byte offered
  output logic [7:0]       diskData,      // Disk byte
  output logic             diskSectorEnd, // Sector finished pulse
  output logic             diskTrackEnd,  // Track finished pulse
  output logic [11:0]      headPos        // Head cylinder
);
  timeunit 1ns;
  timeprecision 1ns;
  int   nb;
  int   ns;
  logic gap;
  assign diskValid = execActive && !gap && !diskTrackEnd;
  // Idle stream shows the inverse pattern
  assign diskData = diskValid ? PAT : ~PAT;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      headPos <= 12'h000;
      nb <= 0;
      ns <= 0;
      gap <= 1'b0;
      diskSectorEnd <= 1'b0;
      diskTrackEnd <= 1'b0;
    end else begin
      diskSectorEnd <= 1'b0;
      diskTrackEnd <= 1'b0;
      if (stepOut) begin
        headPos <= stepDir ? headPos + 12'h001 : headPos - 12'h001;
      end
      if (!execActive) begin
        nb <= 0;
        ns <= 0;
        gap <= 1'b0;
      end else if (diskValid && diskReady) begin
        nb <= (nb == SEC_BYTES - 1) ? 0 : nb + 1;
        if (nb == SEC_BYTES - 1) begin
          diskSectorEnd <= 1'b1;
          gap <= 1'b1;
          ns <= ns + 1;
        end
      end else if (gap) begin
        gap <= 1'b0;
        if (ns == TRK_SECS) begin
          ns <= 0;
          diskTrackEnd <= 1'b1;
        end
      end
    end
  end
endmodule

// ### fsc_cmd_test.sv
module fsc_cmd_test;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
  logic        clk = 0, rst_b = 0, cmdValid = 0, resReady = 0, extended_track_range = 0;
  logic        scanValid = 1;
  logic [7:0]  cmdData = 8'h00, drvSt = 8'h3C, scanData = 8'hA5;
  logic        cmdReady, resValid, diskValid, diskReady, secEnd, trkEnd;
  logic        execActive, encSel, mtEn, cntEn, stepOut, stepDir, irq, nDma;
  logic        scRdy, skDel, hdSel;
  logic [1:0]  exDrv;
  logic [7:0]  exSec, exSize, exLen;
  logic [7:0]  resData, diskData;
  logic [3:0]  srt, mft;
  logic [6:0]  mnt;
  logic [11:0] headPos;
  int          n_fail = 0;
  int          n_compared = 0;
  always #25 clk = ~clk;
  fsc_cmd #(.UNIT_CYC(4)) u_dut (.clk(clk), .rst_b(rst_b),
    .cmdValid(cmdValid), .cmdData(cmdData), .cmdReady(cmdReady),
    .resValid(resValid), .resData(resData), .resReady(resReady),
    .extendedTrackRange(extended_track_range), .driveStatus(drvSt), .diskValid(diskValid),
    .diskData(diskData), .diskReady(diskReady), .diskSectorEnd(secEnd),
    .diskTrackEnd(trkEnd), .scanValid(scanValid), .scanData(scanData),
    .scanReady(scRdy), .execActive(execActive), .encodingSelect(encSel),
    .multiTrackEnable(mtEn), .skipDeletedEnable(skDel), .headSelect(hdSel),
    .execDrive(exDrv), .execSector(exSec), .execSectorSize(exSize),
    .execLength(exLen),
    .countEnableBit(cntEn), .stepOut(stepOut), .stepDir(stepDir),
    .irq(irq), .stepRateTime(srt), .motorOffTime(mft), .motorOnTime(mnt),
    .nonDmaSelect(nDma));
  fsc_drive_model u_drive (.clk(clk), .rst_b(rst_b), .execActive(execActive),
    .diskReady(diskReady), .stepOut(stepOut), .stepDir(stepDir),
    .diskValid(diskValid), .diskData(diskData), .diskSectorEnd(secEnd),
    .diskTrackEnd(trkEnd), .headPos(headPos));
  task automatic send(input logic e, input logic [7:0] b[$]);
    @(posedge clk);
    extended_track_range <= e;
    foreach (b[i]) begin
      cmdValid <= 1'b1;
      cmdData <= b[i];
      do @(negedge clk); while (cmdReady !== 1'b1);
      @(posedge clk);
    end
    cmdValid <= 1'b0;
  endtask
  task automatic get(input logic [7:0] e[$]);
    @(posedge clk);
    resReady <= 1'b1;
    foreach (e[i]) begin
      do @(negedge clk); while (resValid !== 1'b1);
      `CHK(resData, e[i])
      @(posedge clk);
    end
    resReady <= 1'b0;
    @(negedge clk);
    `CHK(resValid, 1'b0)
  endtask
  task automatic waitIrq;
    for (int k = 0; k < 8000 && irq !== 1'b1; k++) @(negedge clk);
    `CHK(irq, 1'b1)
  endtask
  task automatic t_version;
    send(0, {8'h10});
    get({8'h90});
  endtask
  task automatic t_specify;
    send(0, {8'h03, 8'hC5, 8'h55});
    repeat (4) @(negedge clk);
    `CHK(resValid, 1'b0)
    `CHK({srt, mft, mnt, nDma}, 16'hC555)
  endtask
  task automatic t_seeks;
    send(0, {8'h0F, 8'h01, 8'h05});
    @(negedge clk);
    `CHK(resValid, 1'b0)
    waitIrq();
    `CHK(headPos, 12'h005)
    send(0, {8'h08});
    get({8'h21, 8'h05});
    `CHK(irq, 1'b0)
    send(1, {8'h8F, 8'h01, 8'h02});
    waitIrq();
    `CHK({resValid, headPos}, 13'h0003)
    send(1, {8'h08});
    get({8'h21, 8'h03, 8'h00});
    send(1, {8'h0F, 8'h01, 8'h00, 8'h10});
    waitIrq();
    `CHK(headPos, 12'h100)
    send(1, {8'h08});
    get({8'h21, 8'h00, 8'h10});
    send(0, {8'h08});
    get({8'h80});
  endtask
  task automatic t_track;
    send(0, {8'h21, 8'h35, 8'h00});
    get({8'h01});
    send(0, {8'h61, 8'h32, 8'h7E});
    get({8'h7E});
    send(0, {8'h21, 8'h32, 8'h00});
    get({8'h7E});
    send(0, {8'h04, 8'h05});
    get({8'h3C});
    // Unknown opcode answers with the invalid status byte
    send(0, {8'h00});
    get({8'h80});
  endtask
  task automatic t_verify;
    send(0, {8'h56, 8'h80, 8'h07, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1B, 8'h02});
    do @(negedge clk); while (execActive !== 1'b1);
    `CHK({encSel, cntEn}, 2'b11)
    `CHK({hdSel, exDrv, skDel, scRdy}, 5'b00000)
    `CHK({exSec, exSize, exLen}, 24'h010202)
    get({8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h03, 8'h02});
  endtask
  task automatic t_scan;
    logic [7:0] ops[3] = '{8'h91, 8'h9D, 8'hB9};
    foreach (ops[i]) begin
      send(0, {ops[i], 8'h00, 8'h04, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1B, 8'h01});
      do @(negedge clk); while (execActive !== 1'b1);
      `CHK(mtEn, 1'b1)
      `CHK({skDel, scRdy}, {ops[i][5], 1'b1})
      get({8'h04, 8'h00, 8'h08, 8'h04, 8'h01, 8'h04, 8'h02});
    end
    @(posedge clk);
    scanData <= 8'h5A;
    send(0, {8'h11, 8'h00, 8'h04, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1B, 8'h01});
    get({8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h04, 8'h02});
  endtask
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK({cmdReady, resValid, irq, stepOut}, 4'h8)
    t_version();
    t_specify();
    t_seeks();
    t_track();
    t_verify();
    t_scan();
    give_verdict();
  end
endmodule
